/* design/mde_pkg.sv */
package mde_pkg;
  // Widths
  localparam int PC_W = 11;
  localparam int STACK_DEPTH = 6;
  // Reset values and software interrupt vector
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [10:0] VEC_SWI = 11'h001;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] TMODE_RESET = 8'h00;
  localparam logic [1:0] THP_RESET = 2'h0;
  // Status bit positions
  localparam int C_BIT = 0;
  localparam int HALF_C_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int PWRDN_BIT = 3;
  localparam int TIMEOUT_BIT = 4;
  localparam int PAGE_BIT = 5;
  localparam logic [7:0] STATUS_WR_MASK = 8'h27;
  // Timer mode bit: prescaler owned by watchdog
  localparam int PSA_BIT = 3;
  // Lowest valid port-control index
  localparam logic [3:0] PORT_CTRL_MIN = 4'h5;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_WORK = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_TMODE = 8'h0c;
  localparam logic [7:0] REG_TABLE = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  // Sequencer states
  typedef enum logic [1:0] {SEQ_RUN, SEQ_TABLE, SEQ_HOLD} mde_seq_e;
  // File register write port
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } mde_rf_wr_s;
endpackage

/* design/mde_core.sv */
// How it works
// - Register forms: opcode high, dest bit, 7-bit address; store form forces dest 1.
// - Add-with-carry register: work plus file plus carry, flags C, half carry, Z.
// - Add-with-carry immediate: work plus literal plus carry into work, flags C, half carry, Z.
// - Plain add register or immediate, no carry-in, flags C, half carry, Z.
// - AND, OR, XOR, complement touch only Z; immediates write work.
// - Bit clear and set force one selected bit, flags untouched.
// - Bit test skip discards prefetched word, runs no-op, two cycles.
// - Short call pushes return, PC low from literal, bit8 zero, bit9 page.
// - Computed call pushes return, PC from table-high pointer and work.
// - Clear work writes zero and sets Z in one cycle.
// - Clear file register writes zero and sets Z in one cycle.
// - Watchdog kick clears watchdog, prescaler if assigned, sets timeout and power-down flags.
// - Complement writes inverse of file register to dest, only Z.
// - Compare does file minus work, updates C and Z, writes nothing.
// - Literal forms carry 8-bit immediate; short branch 9-bit target, two cycles.
// - Zero-operand codes: standby, kick, timer mode load, irq on, irq off.
// - Port-control load and read move work, index valid 5 to 15.
// - Special-function load and read move work, one cycle, no flags.
// - Table read fetches program word into table-high result and work, two cycles.
// - Inc and dec skip write dest, no flags, skip when result zero.
// - Subtract operand minus work; borrow forms also subtract the carry flag; C, half carry, Z.
// - Return with literal loads work and pops PC, two cycles.
// - Return from interrupt pops and enables irqs; plain return pops; two cycles.
// - Short branch loads PC bits 8..0 from literal, bit 9 from page.
// - Far call and far branch load 11-bit PC; call pushes first.
// - Software interrupt pushes return and jumps to 001h in three cycles.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module mde_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic [10:0] pm_addr_o,
  input wire logic [13:0] pm_data_i,
  output logic [6:0] rf_raddr_o,
  input wire logic [7:0] rf_rdata_i,
  output mde_pkg::mde_rf_wr_s rf_wr_o,
  output logic gie_o,
  output logic wdt_clr_o,
  output logic psc_clr_o,
  output logic sleep_o,
  output logic [7:0] tmode_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // Four-bit-split adder giving {carry, half carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  mde_pkg::mde_seq_e seq_r;
  logic [13:0] ir_r;
  logic valid_r;
  logic [10:0] ret_r;
  logic [7:0] acc_r;
  logic [7:0] status_r;
  logic [1:0] thp_r;
  logic [5:0] thr_r;
  logic ctrl_r;
  logic [10:0] stk_r [mde_pkg::STACK_DEPTH];
  logic [2:0] sp_r;
  logic [7:0] port_ctrl_r [16];
  logic [7:0] spec_fn_r [16];
  logic act;
  logic exec;
  logic [7:0] opnd;
  logic [7:0] lit;
  logic [7:0] res;
  logic [9:0] sum;
  logic [7:0] bmask;
  logic [2:0] sp_dn;
  logic wr_d, wr_acc, wr_file;
  logic set_z, set_c, set_hc, c_n, hc_n;
  logic jump, push, pop, skip, tbl, hold;
  logic [10:0] target;
  logic do_sleep, do_kick, ld_tm, irq_on, irq_off, ld_io, ld_sf;
  logic wb_req;

  assign act = valid_r && (seq_r == mde_pkg::SEQ_RUN);
  assign exec = ce_i && act;
  assign lit = ir_r[7:0];
  assign bmask = 8'h01 << ir_r[9:7];
  assign sp_dn = (sp_r == 3'h0) ? 3'(mde_pkg::STACK_DEPTH - 1) : sp_r - 3'h1;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Decode and compute one instruction
  always_comb begin
    opnd = (rf_wr_o.we && rf_wr_o.addr == rf_raddr_o) ? rf_wr_o.data : rf_rdata_i;
    res = 8'h00;
    sum = 10'h000;
    wr_d = 1'b0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    set_z = 1'b0;
    set_c = 1'b0;
    set_hc = 1'b0;
    c_n = status_r[mde_pkg::C_BIT];
    hc_n = status_r[mde_pkg::HALF_C_BIT];
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    skip = 1'b0;
    tbl = 1'b0;
    hold = 1'b0;
    target = pm_addr_o;
    do_sleep = 1'b0;
    do_kick = 1'b0;
    ld_tm = 1'b0;
    irq_on = 1'b0;
    irq_off = 1'b0;
    ld_io = 1'b0;
    ld_sf = 1'b0;
    if (act) begin
      case (ir_r[13:12])
        2'b00: begin
          case (ir_r[11:8])
            4'h0: begin
              if (ir_r[7]) begin
                res = acc_r;
                wr_file = 1'b1;
              end else begin
                case (ir_r[6:4])
                  3'h0: begin
                    case (ir_r[3:0])
                      4'h0: ;
                      4'h1: do_sleep = 1'b1;
                      4'h2: do_kick = 1'b1;
                      4'h3: ld_tm = 1'b1;
                      4'h4: irq_on = 1'b1;
                      default: ld_io = 1'b1;
                    endcase
                  end
                  3'h1: begin
                    case (ir_r[3:0])
                      4'h0: begin
                        jump = 1'b1;
                        pop = 1'b1;
                        target = stk_r[sp_dn];
                      end
                      4'h1: begin
                        jump = 1'b1;
                        pop = 1'b1;
                        irq_on = 1'b1;
                        target = stk_r[sp_dn];
                      end
                      4'h2: begin
                        c_n = (acc_r[7:4] > 4'h9) || status_r[mde_pkg::C_BIT];
                        res = acc_r + {(c_n ? 4'h6 : 4'h0),
                          ((acc_r[3:0] > 4'h9) || status_r[mde_pkg::HALF_C_BIT]) ? 4'h6 : 4'h0};
                        set_c = 1'b1;
                        wr_acc = 1'b1;
                      end
                      4'h3: irq_off = 1'b1;
                      4'h4: begin
                        res = tmode_o;
                        wr_acc = 1'b1;
                      end
                      default: begin
                        res = port_ctrl_r[ir_r[3:0]];
                        wr_acc = 1'b1;
                      end
                    endcase
                  end
                  3'h2: ld_sf = 1'b1;
                  3'h3: begin
                    res = spec_fn_r[ir_r[3:0]];
                    wr_acc = 1'b1;
                  end
                  default: ;
                endcase
              end
            end
            4'h1: begin
              res = opnd;
              wr_d = 1'b1;
              set_z = 1'b1;
            end
            4'h2: begin
              if (ir_r[7]) begin
                wr_file = 1'b1;
                set_z = 1'b1;
              end else begin
                case (ir_r[6:0])
                  7'h00: begin
                    wr_acc = 1'b1;
                    set_z = 1'b1;
                  end
                  7'h10: begin
                    jump = 1'b1;
                    push = 1'b1;
                    hold = 1'b1;
                    target = mde_pkg::VEC_SWI;
                  end
                  7'h11: tbl = 1'b1;
                  7'h12: begin
                    jump = 1'b1;
                    push = 1'b1;
                    target = {1'b0, thp_r, acc_r};
                  end
                  7'h13: begin
                    jump = 1'b1;
                    target = {1'b0, thp_r, acc_r};
                  end
                  default: ;
                endcase
              end
            end
            4'h3, 4'h4: begin
              // Opcode bit 10 tells subtract (0100) from add (0011)
              if (ir_r[10]) sum = add8(opnd, ~acc_r, 1'b1);
              else sum = add8(acc_r, opnd, 1'b0);
              {c_n, hc_n, res} = sum;
              {set_c, set_hc, set_z, wr_d} = 4'hf;
            end
            4'h5, 4'h6: begin
              res = ir_r[8] ? opnd + 8'h01 : opnd - 8'h01;
              wr_d = 1'b1;
              set_z = 1'b1;
            end
            4'h7: begin
              res = ~opnd;
              wr_d = 1'b1;
              set_z = 1'b1;
            end
            4'h8, 4'h9, 4'ha: begin
              res = (ir_r[9:8] == 2'h0) ? acc_r & opnd :
                    (ir_r[9:8] == 2'h1) ? acc_r | opnd : acc_r ^ opnd;
              wr_d = 1'b1;
              set_z = 1'b1;
            end
            4'hb: begin
              res = {status_r[mde_pkg::C_BIT], opnd[7:1]};
              c_n = opnd[0];
              {set_c, wr_d} = 2'h3;
            end
            4'hc: begin
              res = {opnd[6:0], status_r[mde_pkg::C_BIT]};
              c_n = opnd[7];
              {set_c, wr_d} = 2'h3;
            end
            4'hd: begin
              res = {opnd[3:0], opnd[7:4]};
              wr_d = 1'b1;
            end
            default: begin
              res = ir_r[8] ? opnd - 8'h01 : opnd + 8'h01;
              wr_d = 1'b1;
              skip = (res == 8'h00);
            end
          endcase
        end
        2'b01: begin
          case (ir_r[11:8])
            4'h0: begin
              res = lit;
              wr_acc = 1'b1;
              jump = 1'b1;
              pop = 1'b1;
              target = stk_r[sp_dn];
            end
            4'h1: begin
              res = lit;
              wr_acc = 1'b1;
            end
            4'h2, 4'h3, 4'h4: begin
              res = (ir_r[9:8] == 2'h2) ? acc_r & lit :
                    (ir_r[9:8] == 2'h3) ? acc_r | lit : acc_r ^ lit;
              wr_acc = 1'b1;
              set_z = 1'b1;
            end
            4'h9: begin
              jump = 1'b1;
              push = 1'b1;
              target = {1'b0, status_r[mde_pkg::PAGE_BIT], 1'b0, lit};
            end
            4'ha, 4'hb: begin
              jump = 1'b1;
              target = {1'b0, status_r[mde_pkg::PAGE_BIT], ir_r[8:0]};
            end
            4'hf: ;
            default: begin
              case (ir_r[11:8])
                4'h5: sum = add8(acc_r, lit, 1'b0);
                4'h6: sum = add8(acc_r, lit, status_r[mde_pkg::C_BIT]);
                4'h7: sum = add8(lit, ~acc_r, 1'b1);
                4'h8: sum = add8(lit, ~acc_r, !status_r[mde_pkg::C_BIT]);
                4'hc: sum = add8(acc_r, opnd, status_r[mde_pkg::C_BIT]);
                4'hd: sum = add8(opnd, ~acc_r, !status_r[mde_pkg::C_BIT]);
                default: sum = add8(opnd, ~acc_r, 1'b1);
              endcase
              {c_n, hc_n, res} = sum;
              set_c = 1'b1;
              set_z = 1'b1;
              set_hc = (ir_r[11:8] != 4'he);
              wr_acc = (ir_r[11:8] < 4'h9);
              wr_d = (ir_r[11:8] == 4'hc) || (ir_r[11:8] == 4'hd);
            end
          endcase
        end
        2'b10: begin
          case (ir_r[11:10])
            2'b11: begin
              res = opnd & ~bmask;
              wr_file = 1'b1;
            end
            2'b10: begin
              res = opnd | bmask;
              wr_file = 1'b1;
            end
            2'b01: skip = ((opnd & bmask) == 8'h00);
            default: skip = ((opnd & bmask) != 8'h00);
          endcase
        end
        default: begin
          jump = 1'b1;
          push = !ir_r[11];
          target = ir_r[10:0];
        end
      endcase
      wr_acc = wr_acc || (wr_d && !ir_r[7]);
      wr_file = wr_file || (wr_d && ir_r[7]);
    end
  end

  // Fetch sequencer with prefetch flush
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_r <= mde_pkg::SEQ_RUN;
      pm_addr_o <= mde_pkg::PC_RESET;
      ir_r <= 14'h0000;
      valid_r <= 1'b0;
      ret_r <= mde_pkg::PC_RESET;
      rf_raddr_o <= 7'h00;
    end else if (ce_i) begin
      case (seq_r)
        mde_pkg::SEQ_RUN: begin
          ir_r <= pm_data_i;
          rf_raddr_o <= pm_data_i[6:0];
          if (jump) begin
            pm_addr_o <= target;
            valid_r <= 1'b0;
            seq_r <= hold ? mde_pkg::SEQ_HOLD : mde_pkg::SEQ_RUN;
          end else if (tbl) begin
            pm_addr_o <= {1'b0, thp_r, acc_r};
            ret_r <= pm_addr_o + 11'h001;
            valid_r <= 1'b1;
            seq_r <= mde_pkg::SEQ_TABLE;
          end else begin
            pm_addr_o <= pm_addr_o + 11'h001;
            valid_r <= !skip;
          end
        end
        mde_pkg::SEQ_TABLE: begin
          pm_addr_o <= ret_r;
          seq_r <= mde_pkg::SEQ_RUN;
        end
        default: begin
          valid_r <= 1'b0;
          seq_r <= mde_pkg::SEQ_RUN;
        end
      endcase
    end
  end

  // Work register
  always_ff @(posedge clk_i) begin
    if (rst_i) acc_r <= mde_pkg::WORK_RESET;
    else if (ce_i && seq_r == mde_pkg::SEQ_TABLE) acc_r <= pm_data_i[7:0];
    else if (exec && wr_acc) acc_r <= res;
  end

  // Status flags; instruction updates override bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= mde_pkg::STATUS_RESET;
    end else if (ce_i) begin
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == mde_pkg::REG_STATUS)
        status_r <= (status_r & ~mde_pkg::STATUS_WR_MASK) | (wb_dat_i[7:0] & mde_pkg::STATUS_WR_MASK);
      if (exec) begin
        if (set_c) status_r[mde_pkg::C_BIT] <= c_n;
        if (set_hc) status_r[mde_pkg::HALF_C_BIT] <= hc_n;
        if (set_z) status_r[mde_pkg::Z_BIT] <= (res == 8'h00);
        if (do_sleep || do_kick) status_r[mde_pkg::TIMEOUT_BIT] <= 1'b1;
        if (do_sleep) status_r[mde_pkg::PWRDN_BIT] <= 1'b0;
        if (do_kick) status_r[mde_pkg::PWRDN_BIT] <= 1'b1;
      end
    end
  end

  // Return stack, circular
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_r <= 3'h0;
    end else if (exec && push) begin
      stk_r[sp_r] <= pm_addr_o;
      sp_r <= (sp_r == 3'(mde_pkg::STACK_DEPTH - 1)) ? 3'h0 : sp_r + 3'h1;
    end else if (exec && pop) begin
      sp_r <= sp_dn;
    end
  end

  // File register write port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rf_wr_o <= '0;
    end else if (ce_i) begin
      rf_wr_o.we <= exec && wr_file;
      rf_wr_o.addr <= ir_r[6:0];
      rf_wr_o.data <= res;
    end
  end

  // Special registers and irq enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmode_o <= mde_pkg::TMODE_RESET;
      gie_o <= 1'b0;
      thp_r <= mde_pkg::THP_RESET;
      thr_r <= 6'h00;
    end else if (ce_i) begin
      if (exec && ld_tm) tmode_o <= acc_r;
      if (exec && irq_on) gie_o <= 1'b1;
      if (exec && irq_off) gie_o <= 1'b0;
      if (exec && ld_io && ir_r[3:0] >= mde_pkg::PORT_CTRL_MIN) port_ctrl_r[ir_r[3:0]] <= acc_r;
      if (exec && ld_sf) spec_fn_r[ir_r[3:0]] <= acc_r;
      if (seq_r == mde_pkg::SEQ_TABLE) thr_r <= pm_data_i[13:8];
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == mde_pkg::REG_TABLE) thp_r <= wb_dat_i[1:0];
    end
  end

  // Watchdog and standby strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_clr_o <= 1'b0;
      psc_clr_o <= 1'b0;
      sleep_o <= 1'b0;
    end else if (ce_i) begin
      wdt_clr_o <= exec && (do_kick || do_sleep);
      psc_clr_o <= exec && do_kick && tmode_o[mde_pkg::PSA_BIT];
      sleep_o <= exec && do_sleep;
    end
  end

  // Wishbone slave, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_r <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == mde_pkg::REG_CTRL) ctrl_r <= wb_dat_i[0];
      case (wb_adr_i)
        mde_pkg::REG_STATUS: wb_dat_o <= {24'h0, status_r};
        mde_pkg::REG_WORK: wb_dat_o <= {24'h0, acc_r};
        mde_pkg::REG_PC: wb_dat_o <= {21'h0, pm_addr_o};
        mde_pkg::REG_TMODE: wb_dat_o <= {24'h0, tmode_o};
        mde_pkg::REG_TABLE: wb_dat_o <= {18'h0, thr_r, 6'h0, thp_r};
        mde_pkg::REG_CTRL: wb_dat_o <= {28'h0, sp_r, ctrl_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  store_fixed_a: assert property (exec && ir_r[13:7] == 7'h01 |=> rf_wr_o.we &&
    rf_wr_o.addr == $past(ir_r[6:0]) && rf_wr_o.data == $past(acc_r)) else $error("store failed");
  adc_imm_a: assert property (exec && ir_r[13:8] == 6'h16 |=>
    acc_r == 8'($past(acc_r) + $past(ir_r[7:0]) + {7'h0, $past(status_r[0])})) else $error("adc wrong");
  logic_flags_a: assert property (exec && ir_r[13:8] == 6'h12 |=>
    $stable(status_r[1:0])) else $error("logic op touched carry");
  bit_clear_a: assert property (exec && ir_r[13:10] == 4'hb |=> rf_wr_o.we &&
    rf_wr_o.data[$past(ir_r[9:7])] == 1'b0 && $stable(status_r[2:0])) else $error("bit clear bad");
  skip_flush_a: assert property (exec && skip |=> !valid_r) else $error("skip kept word");
  call_dest_a: assert property (exec && ir_r[13:8] == 6'h19 |=> pm_addr_o ==
    {1'b0, $past(status_r[5]), 1'b0, $past(ir_r[7:0])} && !valid_r) else $error("call target");
  clear_work_a: assert property (exec && ir_r == 14'h0200 |=> acc_r == 8'h00 &&
    status_r[2]) else $error("clear work bad");
  kick_flags_a: assert property (exec && ir_r == 14'h0002 |=> wdt_clr_o &&
    status_r[4:3] == 2'h3) else $error("kick flags bad");
  cmp_keeps_a: assert property (exec && ir_r[13:7] == 7'h3d |=> !rf_wr_o.we &&
    $stable(acc_r)) else $error("compare wrote");
  swi_vec_a: assert property (exec && ir_r == 14'h0210 |=> pm_addr_o == mde_pkg::VEC_SWI &&
    seq_r == mde_pkg::SEQ_HOLD) else $error("swi bad");

  skip_c: cover property (exec && skip);
  table_c: cover property (exec && tbl ##1 seq_r == mde_pkg::SEQ_TABLE);
  call_ret_c: cover property (exec && push ##[1:20] exec && pop);
  swi_c: cover property (exec && hold);

endmodule // mde_core

/* sim/mde_mem_model.sv */
`timescale 1ns/1ps
module mde_mem_model (
  input wire logic clk_i,
  input wire logic [10:0] pm_addr_i,
  output logic [13:0] pm_data_o,
  input wire logic [6:0] rf_raddr_i,
  output logic [7:0] rf_rdata_o,
  input wire mde_pkg::mde_rf_wr_s rf_wr_i
);
  logic [13:0] prog [0:2047];
  logic [7:0] regs [0:127];
  // Asynchronous reads of program word and file register
  assign pm_data_o = prog[pm_addr_i];
  assign rf_rdata_o = regs[rf_raddr_i];
  // Empty program memory decodes as no-operation
  initial begin
    for (int i = 0; i < 2048; i++) prog[i] = 14'h0000;
    for (int i = 0; i < 128; i++) regs[i] = 8'h00;
  end
  // File register write at the edge ending the strobe cycle
  always @(posedge clk_i) begin
    if (rf_wr_i.we === 1'b1) regs[rf_wr_i.addr] <= rf_wr_i.data;
  end
endmodule // mde_mem_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, ack, gie, wdt, psc, slp;
  logic [7:0] adr = 8'h00, tmode;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, rv;
  logic [10:0] pm_addr;
  logic [13:0] pm_data;
  logic [6:0] rf_raddr;
  logic [7:0] rf_rdata;
  mde_pkg::mde_rf_wr_s rf_wr;
  int mismatches = 0, samples_checked = 0, wdt_n = 0, psc_n = 0, slp_n = 0;
  // Clock at 25 MHz
  always #20 clk_i = ~clk_i;
  mde_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pm_addr_o(pm_addr), .pm_data_i(pm_data),
    .rf_raddr_o(rf_raddr), .rf_rdata_i(rf_rdata), .rf_wr_o(rf_wr), .gie_o(gie), .wdt_clr_o(wdt),
    .psc_clr_o(psc), .sleep_o(slp), .tmode_o(tmode), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));
  mde_mem_model PM (.clk_i(clk_i), .pm_addr_i(pm_addr), .pm_data_o(pm_data), .rf_raddr_i(rf_raddr),
    .rf_rdata_o(rf_rdata), .rf_wr_i(rf_wr));
  // Watchdog, prescaler and standby pulse counters
  always @(posedge clk_i) begin
    if (wdt === 1'b1) wdt_n++;
    if (psc === 1'b1) psc_n++;
    if (slp === 1'b1) slp_n++;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Classic single Wishbone cycle, held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) check("bus ack", 0, 1);
    rv = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0);
    check(name, rv, exp);
  endtask
  // Reset, then wait for the fetch pointer to reach the closing loop
  task automatic run_to(input logic [10:0] stop);
    int n;
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    n = 0;
    while (pm_addr !== stop && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (pm_addr !== stop) check("fetch loop", 0, 1);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd("status reset", mde_pkg::REG_STATUS, 32'h18);
    rd("work reset", mde_pkg::REG_WORK, 32'h00);
    // Arithmetic, bit and skip sequence
    PM.prog[0] = 14'h11ff; PM.prog[1] = 14'h1501; PM.prog[2] = 14'h1600; PM.prog[3] = 14'h00a1;
    PM.prog[4] = 14'h2ba1; PM.prog[5] = 14'h23a1; PM.prog[6] = 14'h1155; PM.prog[7] = 14'h0721;
    PM.prog[8] = 14'h1ea1; PM.prog[9] = 14'h1a09;
    run_to(11'h009);
    check("file 21", PM.regs[8'h21], 32'h81);
    rd("work", mde_pkg::REG_WORK, 32'h7e);
    rd("status", mde_pkg::REG_STATUS, 32'h19);
    wb_cycle(1'b1, mde_pkg::REG_STATUS, 32'hff);
    rd("status write", mde_pkg::REG_STATUS, 32'h3f);
    wb_cycle(1'b1, 8'h3c, 32'hff);
    rd("unmapped", 8'h3c, 32'h0);
    // Call, literal return, watchdog kick and irq enable
    PM.prog[0] = 14'h1910; PM.prog[1] = 14'h00a2; PM.prog[2] = 14'h0002; PM.prog[3] = 14'h0004;
    PM.prog[4] = 14'h1a04; PM.prog[16] = 14'h105a;
    wdt_n = 0;
    psc_n = 0;
    run_to(11'h004);
    check("file 22", PM.regs[8'h22], 32'h5a);
    check("wdt pulses", wdt_n, 32'h1);
    check("psc pulses", psc_n, 32'h0);
    check("gie", gie, 32'h1);
    rd("status kick", mde_pkg::REG_STATUS, 32'h18);
    // Timer mode, standby, kick, decimal adjust, register add and subtract
    PM.prog[0] = 14'h1108;
    PM.prog[1] = 14'h0003;
    PM.prog[2] = 14'h0001;
    PM.prog[3] = 14'h0002;
    PM.prog[4] = 14'h1138;
    PM.prog[5] = 14'h1545;
    PM.prog[6] = 14'h0012;
    PM.prog[7] = 14'h00b0;
    PM.prog[8] = 14'h1105;
    PM.prog[9] = 14'h03b0;
    PM.prog[10] = 14'h0430;
    PM.prog[11] = 14'h1a0b;
    wdt_n = 0;
    psc_n = 0;
    slp_n = 0;
    run_to(11'h00b);
    check("tmode", tmode, 32'h08);
    check("file 30", PM.regs[8'h30], 32'h88);
    check("wdt pulses 2", wdt_n, 32'h2);
    check("psc pulses 2", psc_n, 32'h1);
    check("sleep pulses", slp_n, 32'h1);
    rd("work sub", mde_pkg::REG_WORK, 32'h83);
    rd("status sub", mde_pkg::REG_STATUS, 32'h1b);
    // Software interrupt, logic immediate, bit clear, clear work, table read
    PM.prog[0] = 14'h0210;
    PM.prog[1] = 14'h11f3;
    PM.prog[2] = 14'h120f;
    PM.prog[3] = 14'h2fa1;
    PM.prog[4] = 14'h0200;
    PM.prog[5] = 14'h0211;
    PM.prog[6] = 14'h1a06;
    run_to(11'h006);
    check("file 21 clear", PM.regs[8'h21], 32'h01);
    rd("work table", mde_pkg::REG_WORK, 32'h10);
    rd("table high", mde_pkg::REG_TABLE, 32'h0200);
    rd("stack depth", mde_pkg::REG_CTRL, 32'h2);
    rd("status clear", mde_pkg::REG_STATUS, 32'h1c);
    stop_test();
  end
endmodule // tb
